// ==== zapc_pkg.sv ====
// Constants, field layouts and carrier types of the auxiliary pin control block
//
// Summary of operation
// - Intermediate zone conveys onward when next clear
// - Active accumulate input holds next arriving item
// - Lane-full block timer must expire before accumulate
// - Lane-full clear timer must expire before release
// - Lane-full disables downstream arrival check
// - Lane-full clear: arriving item releases immediately
// - Upstream wake-up input runs motor to accept
// - Occupied output while upstream zone holds item
// - Occupied output while downstream item awaits discharge
// - Each pin function except lane-full and error output bindable to either zone; lane-full acts on downstream zone only
// - Invert makes input active when pin low
// - Invert drives occupied output low when occupied
// - Merge zone accepts from exactly one source
// - Merge zone discharges only into discharge zone
// - Downstream zone always discharges unless held
// - Upstream zone accepts only on wake-up request
// - Error output active on any module error
package zapc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SECOND_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 24;
  localparam int SEC_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int DEC_W = 8;
  localparam logic [7:0] OFF_PIN_CFG = 8'h00;
  localparam logic [7:0] OFF_LANE_TIME = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  localparam int PIN0_LSB = 0;
  localparam int PIN1_LSB = 8;
  localparam int MERGE_EN_BIT = 16;
  localparam int MERGE_SEL_BIT = 17;
  localparam int BLOCK_LSB = 0;
  localparam int CLEAR_LSB = 8;

  localparam int ST_OCC_LSB = 0;
  localparam int ST_MOTOR_LSB = 2;
  localparam int ST_LANE_HOLD_BIT = 4;
  localparam int ST_LANE_EN_BIT = 5;
  localparam int ST_PIN_LSB = 6;
  localparam int ST_GRANT_LSB = 8;
  localparam int ST_ARR_CHK_BIT = 11;
  localparam int ST_MERGE_DIS_BIT = 12;

  localparam logic [SEC_W-1:0] BLOCK_SEC_RST = 8'h05;
  localparam logic [SEC_W-1:0] CLEAR_SEC_RST = 8'h06;

  // ----------------------------------------------------------------
  // Pin functions and zones
  // ----------------------------------------------------------------
  localparam logic [2:0] FN_EXT = 3'h0;
  localparam logic [2:0] FN_ACCUM = 3'h1;
  localparam logic [2:0] FN_WAKE = 3'h2;
  localparam logic [2:0] FN_LANE_FULL = 3'h3;
  localparam logic [2:0] FN_ERR_OUT = 3'h4;
  localparam logic [2:0] FN_OCC_OUT = 3'h5;

  localparam logic ZONE_UP = 1'b0;
  localparam logic ZONE_DN = 1'b1;
  localparam int N_PIN = 2;
  localparam int N_ZONE = 2;
  localparam int N_SRC = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic invert;
    logic zone;
    logic [2:0] fn;
  } zapc_pin_cfg_s;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } zapc_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } zapc_ahb_rsp_s;

  typedef struct packed {
    logic [N_PIN-1:0] out;
    logic [N_PIN-1:0] oe_n;
  } zapc_pin_drv_s;

  typedef struct packed {
    logic [N_SRC-1:0] grant;
    logic discharge;
  } zapc_merge_s;

endpackage

// ==== zapc_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module zapc_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } zapc_sync_s;

  zapc_sync_s s_q;
  zapc_sync_s s_d;

  always_comb begin
    s_d.stage1 = async_in;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stage2;

endmodule
`default_nettype wire

// ==== zapc_lane_qual.sv ====
// Lane-full block and clear qualification timer
`timescale 1ns/100ps
`default_nettype none
module zapc_lane_qual (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Qualification inputs
  input wire logic enable,
  input wire logic sec_tick,
  input wire logic level,
  input wire logic [zapc_pkg::SEC_W-1:0] block_sec,
  input wire logic [zapc_pkg::SEC_W-1:0] clear_sec,
  // Qualified accumulate state
  output logic hold
);

  typedef struct packed {
    logic hold;
    logic [zapc_pkg::SEC_W-1:0] secs;
  } zapc_lq_s;

  zapc_lq_s s_q;
  zapc_lq_s s_d;
  logic [zapc_pkg::SEC_W-1:0] need;

  // Count is in whole ticks, so the first second may be short by a part of a tick
  always_comb begin
    s_d = s_q;
    need = s_q.hold ? clear_sec : block_sec;
    if (!enable) begin
      s_d = '0;
    end else if (level == s_q.hold) begin
      s_d.secs = '0;
    end else if (s_q.secs >= need) begin
      s_d.hold = level;
      s_d.secs = '0;
    end else if (sec_tick) begin
      s_d.secs = s_q.secs + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hold = s_q.hold;

endmodule
`default_nettype wire

// ==== zapc_top.sv ====
// Auxiliary pin control, zone flow logic and merge arbitration with AHB-Lite registers
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module zapc_top #(
  parameter int unsigned TICK_CYCLES_P = zapc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire zapc_pkg::zapc_ahb_req_s ahb_req,
  input wire logic hready,
  output zapc_pkg::zapc_ahb_rsp_s ahb_rsp,
  // Zone sensor pins, upstream at index 0
  input wire logic [zapc_pkg::N_ZONE-1:0] zone_sensor,
  // Auxiliary two-way pins
  input wire logic [zapc_pkg::N_PIN-1:0] aux_pin_in,
  output zapc_pkg::zapc_pin_drv_s aux_pin,
  // Module status from the controller core
  input wire logic module_err,
  // Zone motors and arrival check
  output logic [zapc_pkg::N_ZONE-1:0] motor_run,
  output logic arrival_chk_en,
  // Merge sources: center, left, right
  input wire logic [zapc_pkg::N_SRC-1:0] src_ready,
  input wire logic discharge_clear,
  output zapc_pkg::zapc_merge_s merge
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    zapc_pkg::zapc_pin_cfg_s [zapc_pkg::N_PIN-1:0] pin_cfg;
    logic merge_en;
    logic merge_sel;
    logic [zapc_pkg::SEC_W-1:0] block_sec;
    logic [zapc_pkg::SEC_W-1:0] clear_sec;
    logic [zapc_pkg::TICK_W-1:0] tick_cnt;
    logic tick;
    logic wr_pend;
    logic rd_pend;
    logic [zapc_pkg::DEC_W-1:0] addr;
    zapc_pkg::zapc_ahb_rsp_s rsp;
    logic [zapc_pkg::N_ZONE-1:0] motor;
    zapc_pkg::zapc_pin_drv_s pin;
    logic arrival_chk;
    zapc_pkg::zapc_merge_s merge;
  } zapc_state_s;

  zapc_state_s s_q;
  zapc_state_s s_d;

  logic [zapc_pkg::N_ZONE-1:0] occ;
  logic [zapc_pkg::N_PIN-1:0] pin_lvl;
  logic [zapc_pkg::N_PIN-1:0] pin_act;
  logic [zapc_pkg::N_ZONE-1:0] accum;
  logic [zapc_pkg::N_ZONE-1:0] wake;
  logic lane_en;
  logic lane_lvl;
  logic lane_hold;
  logic hold_dn;
  logic up_release;
  logic merge_occ;
  logic accept;
  logic [31:0] rdata;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // True when a pin carries input function fn for zone z
  function automatic logic pin_fn_on(input zapc_pkg::zapc_pin_cfg_s cfg,
                                     input logic [2:0] fn, input logic z);
    pin_fn_on = (cfg.fn == fn) && (cfg.zone == z);
  endfunction

  // True when a pin is configured as a driven output
  function automatic logic pin_is_out(input zapc_pkg::zapc_pin_cfg_s cfg);
    pin_is_out = (cfg.fn == zapc_pkg::FN_ERR_OUT) || (cfg.fn == zapc_pkg::FN_OCC_OUT);
  endfunction

  // ----------------------------------------------------------------
  // Pin and sensor synchronisers
  // ----------------------------------------------------------------
  zapc_sync #(
    .W(zapc_pkg::N_ZONE)
  ) u_sens_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(zone_sensor),
    .sync_out(occ)
  );

  zapc_sync #(
    .W(zapc_pkg::N_PIN)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(aux_pin_in),
    .sync_out(pin_lvl)
  );

  // ----------------------------------------------------------------
  // Pin input decode
  // ----------------------------------------------------------------
  always_comb begin
    accum = '0;
    wake = '0;
    lane_en = 1'b0;
    lane_lvl = 1'b0;
    for (int p = 0; p < zapc_pkg::N_PIN; p++) begin
      // An output pin reads its own drive, so it never counts as an input
      pin_act[p] = (pin_lvl[p] ^ s_q.pin_cfg[p].invert) && !pin_is_out(s_q.pin_cfg[p]);
      for (int z = 0; z < zapc_pkg::N_ZONE; z++) begin
        if (pin_fn_on(s_q.pin_cfg[p], zapc_pkg::FN_ACCUM, 1'(z)) && pin_act[p]) begin
          accum[z] = 1'b1;
        end
        if (pin_fn_on(s_q.pin_cfg[p], zapc_pkg::FN_WAKE, 1'(z)) && pin_act[p]) begin
          wake[z] = 1'b1;
        end
      end
      // Lane-full is only meaningful on the most downstream zone
      if (pin_fn_on(s_q.pin_cfg[p], zapc_pkg::FN_LANE_FULL, zapc_pkg::ZONE_DN)) begin
        lane_en = 1'b1;
        lane_lvl = lane_lvl | pin_act[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Lane-full qualification
  // ----------------------------------------------------------------
  zapc_lane_qual u_lane (
    .core_clk(core_clk),
    .rst(rst),
    .enable(lane_en),
    .sec_tick(s_q.tick),
    .level(lane_lvl),
    .block_sec(s_q.block_sec),
    .clear_sec(s_q.clear_sec),
    .hold(lane_hold)
  );

  // ----------------------------------------------------------------
  // Zone flow and register access
  // ----------------------------------------------------------------
  assign hold_dn = occ[zapc_pkg::ZONE_DN] && (accum[zapc_pkg::ZONE_DN] || lane_hold);
  assign up_release = occ[zapc_pkg::ZONE_UP] && !occ[zapc_pkg::ZONE_DN]
                      && !accum[zapc_pkg::ZONE_UP];
  assign merge_occ = occ[s_q.merge_sel];
  assign accept = ahb_req.hsel && ahb_req.htrans[1] && hready;

  always_comb begin
    rdata = '0;
    unique case (s_q.addr)
      zapc_pkg::OFF_PIN_CFG: begin
        rdata[zapc_pkg::PIN0_LSB +: 5] = s_q.pin_cfg[0];
        rdata[zapc_pkg::PIN1_LSB +: 5] = s_q.pin_cfg[1];
        rdata[zapc_pkg::MERGE_EN_BIT] = s_q.merge_en;
        rdata[zapc_pkg::MERGE_SEL_BIT] = s_q.merge_sel;
      end
      zapc_pkg::OFF_LANE_TIME: begin
        rdata[zapc_pkg::BLOCK_LSB +: zapc_pkg::SEC_W] = s_q.block_sec;
        rdata[zapc_pkg::CLEAR_LSB +: zapc_pkg::SEC_W] = s_q.clear_sec;
      end
      zapc_pkg::OFF_STATUS: begin
        rdata[zapc_pkg::ST_OCC_LSB +: zapc_pkg::N_ZONE] = occ;
        rdata[zapc_pkg::ST_MOTOR_LSB +: zapc_pkg::N_ZONE] = s_q.motor;
        rdata[zapc_pkg::ST_LANE_HOLD_BIT] = lane_hold;
        rdata[zapc_pkg::ST_LANE_EN_BIT] = lane_en;
        rdata[zapc_pkg::ST_PIN_LSB +: zapc_pkg::N_PIN] = pin_lvl;
        rdata[zapc_pkg::ST_GRANT_LSB +: zapc_pkg::N_SRC] = s_q.merge.grant;
        rdata[zapc_pkg::ST_ARR_CHK_BIT] = s_q.arrival_chk;
        rdata[zapc_pkg::ST_MERGE_DIS_BIT] = s_q.merge.discharge;
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;

    // One-second time base for the lane-full timers
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == zapc_pkg::TICK_W'(TICK_CYCLES_P - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end

    // Bus: writes finish in one data cycle, reads take one wait state so
    // that a read right after a write sees the new value
    s_d.rsp.hresp = 1'b0;
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      unique case (s_q.addr)
        zapc_pkg::OFF_PIN_CFG: begin
          s_d.pin_cfg[0] = ahb_req.hwdata[zapc_pkg::PIN0_LSB +: 5];
          s_d.pin_cfg[1] = ahb_req.hwdata[zapc_pkg::PIN1_LSB +: 5];
          s_d.merge_en = ahb_req.hwdata[zapc_pkg::MERGE_EN_BIT];
          s_d.merge_sel = ahb_req.hwdata[zapc_pkg::MERGE_SEL_BIT];
        end
        zapc_pkg::OFF_LANE_TIME: begin
          s_d.block_sec = ahb_req.hwdata[zapc_pkg::BLOCK_LSB +: zapc_pkg::SEC_W];
          s_d.clear_sec = ahb_req.hwdata[zapc_pkg::CLEAR_LSB +: zapc_pkg::SEC_W];
        end
        default: begin
        end
      endcase
    end
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.rsp.hrdata = rdata;
      s_d.rsp.hreadyout = 1'b1;
    end
    if (accept) begin
      s_d.addr = ahb_req.haddr[zapc_pkg::DEC_W-1:0];
      if (ahb_req.hwrite) begin
        s_d.wr_pend = 1'b1;
      end else begin
        s_d.rd_pend = 1'b1;
        s_d.rsp.hreadyout = 1'b0;
      end
    end

    // Upstream zone: passes on when clear, accepts only on wake-up
    s_d.motor[zapc_pkg::ZONE_UP] = up_release
      || (wake[zapc_pkg::ZONE_UP] && !occ[zapc_pkg::ZONE_UP]);

    // Downstream zone: always discharges unless held, takes items from upstream
    s_d.motor[zapc_pkg::ZONE_DN] = (occ[zapc_pkg::ZONE_DN] && !hold_dn)
      || up_release
      || (wake[zapc_pkg::ZONE_DN] && !occ[zapc_pkg::ZONE_DN]);

    // No arrival confirmation is expected while lane-full is in use
    s_d.arrival_chk = !lane_en;

    // Output pins
    for (int p = 0; p < zapc_pkg::N_PIN; p++) begin
      s_d.pin.oe_n[p] = !pin_is_out(s_q.pin_cfg[p]);
      unique case (s_q.pin_cfg[p].fn)
        zapc_pkg::FN_OCC_OUT: begin
          s_d.pin.out[p] = occ[s_q.pin_cfg[p].zone] ^ s_q.pin_cfg[p].invert;
        end
        zapc_pkg::FN_ERR_OUT: begin
          s_d.pin.out[p] = module_err ^ s_q.pin_cfg[p].invert;
        end
        default: begin
          s_d.pin.out[p] = 1'b0;
        end
      endcase
    end

    // Merge: one source at a time, granted while the merge zone is empty
    if (!s_q.merge_en) begin
      s_d.merge.grant = '0;
    end else if (merge_occ) begin
      s_d.merge.grant = '0;
    end else if (s_q.merge.grant == '0) begin
      if (src_ready[0]) begin
        s_d.merge.grant = 3'h1;
      end else if (src_ready[1]) begin
        s_d.merge.grant = 3'h2;
      end else if (src_ready[2]) begin
        s_d.merge.grant = 3'h4;
      end
    end
    s_d.merge.discharge = s_q.merge_en && merge_occ && discharge_clear;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.block_sec <= zapc_pkg::BLOCK_SEC_RST;
      s_q.clear_sec <= zapc_pkg::CLEAR_SEC_RST;
      s_q.rsp.hreadyout <= 1'b1;
      s_q.pin.oe_n <= '1;
      s_q.arrival_chk <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ahb_rsp = s_q.rsp;
  assign aux_pin = s_q.pin;
  assign motor_run = s_q.motor;
  assign arrival_chk_en = s_q.arrival_chk;
  assign merge = s_q.merge;

endmodule
`default_nettype wire

// ==== zapc_props.sv ====
// Port-level checker for the auxiliary pin control block
`timescale 1ns/100ps
`default_nettype none
module zapc_props #(
  parameter int unsigned TICK_CYCLES_P = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire zapc_pkg::zapc_ahb_req_s ahb_req,
  input wire logic hready,
  input wire zapc_pkg::zapc_ahb_rsp_s ahb_rsp,
  // Zones and pins
  input wire logic [zapc_pkg::N_ZONE-1:0] zone_sensor,
  input wire zapc_pkg::zapc_pin_drv_s aux_pin,
  input wire logic [zapc_pkg::N_ZONE-1:0] motor_run,
  input wire logic arrival_chk_en,
  // Merge
  input wire logic [zapc_pkg::N_SRC-1:0] src_ready,
  input wire logic discharge_clear,
  input wire zapc_pkg::zapc_merge_s merge
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence req_taken;
    ahb_req.hsel && ahb_req.htrans[1] && hready;
  endsequence
  sequence rd_wait;
    !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_wait_a: assert property (req_taken and !ahb_req.hwrite |=> rd_wait)
    else $error("read wait state wrong");
  write_no_wait_a: assert property (req_taken and ahb_req.hwrite |=> ahb_rsp.hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (ahb_rsp.hresp == 1'b0)
    else $error("response not okay");
  grant_single_a: assert property ($onehot0(merge.grant))
    else $error("more than one merge grant");
  // Fixed priority: the new grant is the lowest ready source
  grant_prio_a: assert property (merge.grant != 3'h0 && $past(merge.grant) == 3'h0 |->
    merge.grant == ($past(src_ready) & ~($past(src_ready) - 3'h1)))
    else $error("merge grant not from ready source");
  discharge_cause_a: assert property (merge.discharge |-> $past(discharge_clear))
    else $error("discharge without clear zone");
  // Pins the device does not drive stay low on the output side
  pin_idle_a: assert property ((aux_pin.out & aux_pin.oe_n) == 2'b00)
    else $error("undriven pin has output high");
  up_motor_a: assert property (motor_run[0] && $past(zone_sensor[1], 3) |->
    !$past(zone_sensor[0], 3))
    else $error("upstream motor runs into occupied zone");
  reset_vals_a: assert property ($fell(rst) |-> motor_run == 2'b00 && aux_pin.oe_n == 2'b11
    && arrival_chk_en && merge == '0)
    else $error("outputs not at reset values");
endmodule
bind zapc_top zapc_props #(.TICK_CYCLES_P(TICK_CYCLES_P)) props_u (
  .core_clk(core_clk), .rst(rst), .ahb_req(ahb_req), .hready(hready), .ahb_rsp(ahb_rsp),
  .zone_sensor(zone_sensor), .aux_pin(aux_pin), .motor_run(motor_run),
  .arrival_chk_en(arrival_chk_en), .src_ready(src_ready),
  .discharge_clear(discharge_clear), .merge(merge)
);
`default_nettype wire

// ==== zapc_plc_model.sv ====
// Behavioural PLC discrete I/O and feeding equipment at the aux pins
`timescale 1ns/100ps
`default_nettype none
module zapc_plc_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin drive and resolved levels
  input wire zapc_pkg::zapc_pin_drv_s aux_pin,
  input wire logic [zapc_pkg::N_PIN-1:0] plc_lvl,
  output logic [zapc_pkg::N_PIN-1:0] aux_wire,
  // Feeder and acceptor requests
  input wire logic feed_req,
  input wire logic accept_hold,
  output logic feed_item
);
  logic item_q;
  always_comb begin
    aux_wire = plc_lvl;
    for (int i = 0; i < zapc_pkg::N_PIN; i++) begin
      if (!aux_pin.oe_n[i]) aux_wire[i] = aux_pin.out[i];
    end
    // Acceptor holds the waiting item on pin 0 while pin 1 reports it
    if (accept_hold && aux_pin.oe_n[0] && !aux_pin.oe_n[1] && aux_pin.out[1]) begin
      aux_wire[0] = 1'b1;
    end
  end
  // Feeder never starts a delivery while pin 1 reads high
  always_ff @(posedge core_clk) begin
    if (rst) item_q <= 1'b0;
    else item_q <= feed_req && (item_q || !aux_wire[1]);
  end
  assign feed_item = item_q;
endmodule
`default_nettype wire

// ==== tb_zone_aux_pin_control.sv ====
// Self-checking testbench of the auxiliary pin control block
`timescale 1ns/100ps
`default_nettype none
module tb_zone_aux_pin_control;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  zapc_pkg::zapc_ahb_req_s req = '0;
  zapc_pkg::zapc_ahb_rsp_s rsp;
  zapc_pkg::zapc_pin_drv_s pin_drv;
  zapc_pkg::zapc_merge_s mrg;
  logic [1:0] sens = 2'b00;
  logic [1:0] plc_lvl = 2'b00;
  logic [1:0] motor;
  logic [1:0] wire_lvl;
  logic [2:0] src_rdy = 3'h0;
  logic err = 1'b0;
  logic dis_clr = 1'b0;
  logic feed = 1'b0;
  logic acc_hold = 1'b0;
  logic feed_item;
  logic arr_chk;
  logic [31:0] rd;
  logic [1:0] mot_tab [4] = '{2'b00, 2'b11, 2'b10, 2'b10};
  int fails = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  zapc_top #(.TICK_CYCLES_P(10)) dut_u (
    .core_clk(core_clk), .rst(rst), .ahb_req(req), .hready(rsp.hreadyout), .ahb_rsp(rsp),
    .zone_sensor({sens[1], sens[0] | feed_item}), .aux_pin_in(wire_lvl), .aux_pin(pin_drv),
    .module_err(err), .motor_run(motor), .arrival_chk_en(arr_chk), .src_ready(src_rdy),
    .discharge_clear(dis_clr), .merge(mrg)
  );
  zapc_plc_model plc_u (
    .core_clk(core_clk), .rst(rst), .aux_pin(pin_drv), .plc_lvl(plc_lvl),
    .aux_wire(wire_lvl), .feed_req(feed), .accept_hold(acc_hold), .feed_item(feed_item)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task test_done;
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 20);
    if (rsp.hreadyout !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req.hsel <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr <= {24'h0, a};
    req.hwrite <= wr;
    req.hsize <= 3'h2;
    wait_rdy();
    req.htrans <= 2'h0;
    req.hsel <= 1'b0;
    req.hwdata <= wd;
    wait_rdy();
    rd = rsp.hrdata;
  endtask
  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  // Pin 0, pin 1 and merge {select, enable} into the pin configuration word
  task cfg(input logic [4:0] p0, input logic [4:0] p1, input logic [1:0] m);
    bus(1'b1, zapc_pkg::OFF_PIN_CFG, {14'h0, m, 3'h0, p1, 3'h0, p0});
  endtask
  function automatic logic [4:0] pc(input logic inv, input logic z, input logic [2:0] fn);
    return {inv, z, fn};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    rdchk("pin_cfg", zapc_pkg::OFF_PIN_CFG, 32'h0);
    rdchk("lane_time", zapc_pkg::OFF_LANE_TIME, 32'h0000_0605);
    rdchk("status", zapc_pkg::OFF_STATUS, 32'h0000_0800);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    rdchk("unmapped", 8'h0c, 32'h0);
    bus(1'b1, zapc_pkg::OFF_LANE_TIME, 32'h0000_0403);
    rdchk("lane_time_wr", zapc_pkg::OFF_LANE_TIME, 32'h0000_0403);
    for (int i = 0; i < 4; i++) begin
      sens <= i[1:0];
      cyc(5);
      chk("motor_default", mot_tab[i], motor);
    end
    // Upstream occupied, downstream clear: only the accumulate input can stop the flow
    sens <= 2'b01;
    for (int v = 0; v < 2; v++) begin
      cfg(pc(v[0], zapc_pkg::ZONE_UP, zapc_pkg::FN_ACCUM), 5'h0, 2'b00);
      plc_lvl <= {1'b0, ~v[0]};
      cyc(5);
      chk("accum_hold", 32'h0, motor);
      plc_lvl <= {1'b0, v[0]};
      cyc(5);
      chk("accum_free", 32'h3, motor);
    end
    cfg(pc(1'b0, zapc_pkg::ZONE_UP, zapc_pkg::FN_WAKE), 5'h0, 2'b00);
    sens <= 2'b00;
    plc_lvl <= 2'b01;
    cyc(5);
    chk("wake_run", 32'h1, motor);
    plc_lvl <= 2'b00;
    cyc(5);
    chk("wake_idle", 32'h0, motor);
    for (int v = 1; v >= 0; v--) begin
      cfg(5'h0, pc(v[0], zapc_pkg::ZONE_UP, zapc_pkg::FN_OCC_OUT), 2'b00);
      sens <= 2'b00;
      cyc(5);
      chk("occ_pin_clear", {v[0], 1'b0}, {pin_drv.out[1], pin_drv.oe_n[1]});
      sens <= 2'b01;
      cyc(5);
      chk("occ_pin_full", {~v[0], 1'b0}, {pin_drv.out[1], pin_drv.oe_n[1]});
    end
    feed <= 1'b1;
    cyc(6);
    chk("feed_blocked", 32'h0, feed_item);
    sens <= 2'b00;
    cyc(8);
    chk("feed_done", 32'h1, feed_item);
    feed <= 1'b0;
    cfg(pc(1'b0, zapc_pkg::ZONE_DN, zapc_pkg::FN_ACCUM),
      pc(1'b0, zapc_pkg::ZONE_DN, zapc_pkg::FN_OCC_OUT), 2'b00);
    acc_hold <= 1'b1;
    sens <= 2'b10;
    cyc(8);
    chk("dn_occ_pin", 32'h1, pin_drv.out[1]);
    chk("dn_held", 32'h0, motor);
    acc_hold <= 1'b0;
    cyc(5);
    chk("dn_release", 32'h2, motor);
    cfg(pc(1'b0, zapc_pkg::ZONE_UP, zapc_pkg::FN_ERR_OUT), 5'h0, 2'b00);
    for (int v = 0; v < 2; v++) begin
      err <= v[0];
      cyc(3);
      chk("err_pin", {v[0], 1'b0}, {pin_drv.out[0], pin_drv.oe_n[0]});
    end
    err <= 1'b0;
    // Ten cycles a second here; one second of slack on each timer
    cfg(pc(1'b0, zapc_pkg::ZONE_DN, zapc_pkg::FN_LANE_FULL), 5'h0, 2'b00);
    cyc(5);
    chk("arrival_chk", 32'h0, arr_chk);
    chk("lane_release", 32'h2, motor);
    plc_lvl <= 2'b01;
    cyc(16);
    chk("block_wait", 32'h2, motor);
    plc_lvl <= 2'b00;
    cyc(4);
    plc_lvl <= 2'b01;
    cyc(16);
    chk("block_restart", 32'h2, motor);
    cyc(30);
    chk("block_hold", 32'h0, motor);
    plc_lvl <= 2'b00;
    cyc(24);
    chk("clear_wait", 32'h0, motor);
    plc_lvl <= 2'b01;
    cyc(3);
    plc_lvl <= 2'b00;
    cyc(24);
    chk("clear_restart", 32'h0, motor);
    cyc(35);
    chk("clear_release", 32'h2, motor);
    cfg(5'h0, 5'h0, 2'b01);
    sens <= 2'b00;
    src_rdy <= 3'b110;
    dis_clr <= 1'b1;
    cyc(4);
    chk("grant_left", 32'h2, mrg.grant);
    src_rdy <= 3'b111;
    cyc(3);
    chk("grant_held", 32'h2, mrg.grant);
    sens <= 2'b01;
    cyc(5);
    chk("merge_discharge", 32'h1, mrg);
    dis_clr <= 1'b0;
    cyc(2);
    chk("discharge_block", 32'h0, mrg);
    sens <= 2'b00;
    cyc(5);
    chk("grant_center", 32'h2, mrg);
    test_done();
  end
endmodule
`default_nettype wire
